// *** rtl/atme_pkg.sv ***
package atme_pkg;
  localparam int unsigned ATME_ENTRIES = 8;
  localparam int unsigned ATME_IDX_W   = 3;
  localparam int unsigned ATME_PADDR_W = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] ATME_IDX_CMD         = 16'h1800;
  localparam logic [15:0] ATME_IDX_STAGE_LOW   = 16'h1801;
  localparam logic [15:0] ATME_IDX_STAGE_HIGH  = 16'h1802;
  localparam logic [15:0] ATME_IDX_CMD_STS     = 16'h1808;
  localparam logic [15:0] ATME_IDX_INGRESS_CFG = 16'h1840;
  localparam int unsigned ATME_CMD_MAKE_BIT  = 2;
  localparam int unsigned ATME_STS_PEND_BIT  = 0;
  localparam int unsigned ATME_STS_FAIL_BIT  = 1;
  localparam int unsigned ATME_CFG_DAPRI_BIT = 0;
  localparam int unsigned ATME_HIGH_W        = 27;
  localparam logic [31:0] ATME_STAGE_LOW_RST  = 32'h0000_0000;
  localparam logic [26:0] ATME_STAGE_HIGH_RST = 27'h000_0000;
  localparam logic [1:0]  ATME_PST_DISABLED   = 2'h0;
  localparam logic [1:0]  ATME_PST_FORWARD    = 2'h3;
  localparam longint unsigned ATME_CLK_HZ       = 64'd25_000_000;
  localparam longint unsigned ATME_AGE_PERIOD_S = 64'd300;
  localparam longint unsigned ATME_AGE_CYCLES   = ATME_AGE_PERIOD_S * ATME_CLK_HZ;

  // layout equals {entry_stage_high[26:0], entry_stage_low}
  typedef struct packed {
    logic        valid;
    logic        age_ovr;
    logic        static_f;
    logic        filter;
    logic        pri_en;
    logic [2:0]  pri;
    logic [2:0]  ports;
    logic [47:0] mac;
  } atme_entry_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  ingress;
    logic [47:0] sa;
    logic [47:0] da;
  } atme_frame_t;

  typedef struct packed {
    logic       valid;
    logic       drop;
    logic [2:0] mask;
    logic       pri_valid;
    logic [2:0] pri;
  } atme_fwd_t;
endpackage

// *** rtl/atme_entry_stage.sv ***
`timescale 1ns/10ps
module atme_entry_stage #(
  parameter longint unsigned AGE_CYCLES = atme_pkg::ATME_AGE_CYCLES
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [atme_pkg::ATME_PADDR_W-1:0]   paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire atme_pkg::atme_frame_t               frame,
  input  wire logic [5:0]                          port_state,
  output atme_pkg::atme_fwd_t                      fwd
);
  import atme_pkg::*;

  localparam logic [32:0] AGE_LAST = 33'(AGE_CYCLES - 64'd1);

  logic [31:0]           stage_low_r;
  logic [ATME_HIGH_W-1:0] stage_high_r;
  logic                  make_r;
  logic                  pending_r;
  logic                  fail_r;
  logic                  dapri_r;
  logic [31:0]           prdata_r;
  logic [32:0]           age_cnt_r;
  atme_entry_t           tbl_r [ATME_ENTRIES];
  atme_fwd_t             fwd_r;

  function automatic logic reg_hit(input logic [ATME_PADDR_W-1:0] a,
                                   input logic [15:0] idx);
    reg_hit = (a[ATME_PADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [ATME_IDX_W:0] find_mac(input logic [47:0] mac);
    find_mac = '0;
    for (int i = ATME_ENTRIES - 1; i >= 0; i--) begin
      if (tbl_r[i].valid && tbl_r[i].mac == mac) begin
        find_mac = {1'b1, ATME_IDX_W'(i)};
      end
    end
  endfunction

  function automatic logic [ATME_IDX_W:0] find_free();
    find_free = '0;
    for (int i = ATME_ENTRIES - 1; i >= 0; i--) begin
      if (!tbl_r[i].valid) begin
        find_free = {1'b1, ATME_IDX_W'(i)};
      end
    end
  endfunction

  function automatic logic [2:0] port_mask(input logic [2:0] sel);
    case (sel)
      3'h0:    port_mask = 3'h1;
      3'h1:    port_mask = 3'h2;
      3'h2:    port_mask = 3'h4;
      3'h4:    port_mask = 3'h3;
      3'h5:    port_mask = 3'h5;
      3'h6:    port_mask = 3'h6;
      3'h7:    port_mask = 3'h7;
      default: port_mask = 3'h0;
    endcase
  endfunction

  // apb decode
  logic acc;
  logic setup;
  logic mapped;
  logic wr_low;
  logic wr_high;
  logic wr_cmd;
  logic wr_cfg;
  assign acc     = psel && penable;
  assign setup   = psel && !penable;
  assign mapped  = reg_hit(paddr, ATME_IDX_CMD) || reg_hit(paddr, ATME_IDX_STAGE_LOW)
                || reg_hit(paddr, ATME_IDX_STAGE_HIGH) || reg_hit(paddr, ATME_IDX_CMD_STS)
                || reg_hit(paddr, ATME_IDX_INGRESS_CFG);
  assign wr_low  = acc && pwrite && reg_hit(paddr, ATME_IDX_STAGE_LOW);
  assign wr_high = acc && pwrite && reg_hit(paddr, ATME_IDX_STAGE_HIGH);
  assign wr_cmd  = acc && pwrite && reg_hit(paddr, ATME_IDX_CMD);
  assign wr_cfg  = acc && pwrite && reg_hit(paddr, ATME_IDX_INGRESS_CFG);
  // zero wait state; read data was captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_low_r  <= ATME_STAGE_LOW_RST;
      stage_high_r <= ATME_STAGE_HIGH_RST;
    end else begin
      if (wr_low) begin
        stage_low_r <= pwdata;
      end
      if (wr_high) begin
        stage_high_r <= pwdata[ATME_HIGH_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dapri_r <= 1'b0;
    end else if (wr_cfg) begin
      dapri_r <= pwdata[ATME_CFG_DAPRI_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (reg_hit(paddr, ATME_IDX_STAGE_LOW)) begin
        prdata_r <= stage_low_r;
      end
      if (reg_hit(paddr, ATME_IDX_STAGE_HIGH)) begin
        prdata_r <= {5'h00, stage_high_r};
      end
      if (reg_hit(paddr, ATME_IDX_CMD)) begin
        prdata_r[ATME_CMD_MAKE_BIT] <= make_r;
      end
      if (reg_hit(paddr, ATME_IDX_CMD_STS)) begin
        prdata_r[ATME_STS_PEND_BIT] <= pending_r;
        prdata_r[ATME_STS_FAIL_BIT] <= fail_r;
      end
      if (reg_hit(paddr, ATME_IDX_INGRESS_CFG)) begin
        prdata_r[ATME_CFG_DAPRI_BIT] <= dapri_r;
      end
    end
  end

  // make-entry handshake: a 0->1 write starts one commit
  logic        make_start;
  logic        commit_go;
  atme_entry_t stage_e;
  logic [ATME_IDX_W:0] c_find;
  logic [ATME_IDX_W:0] f_find;
  logic [ATME_IDX_W-1:0] c_idx;
  logic        c_ok;
  assign make_start = wr_cmd && pwdata[ATME_CMD_MAKE_BIT] && !make_r;
  assign commit_go  = pending_r;
  assign stage_e    = atme_entry_t'({stage_high_r, stage_low_r});
  always_comb c_find = find_mac(stage_e.mac);
  always_comb f_find = find_free();
  assign c_idx      = c_find[ATME_IDX_W] ? c_find[ATME_IDX_W-1:0] : f_find[ATME_IDX_W-1:0];
  assign c_ok       = stage_e.valid ? (c_find[ATME_IDX_W] || f_find[ATME_IDX_W])
                                    : c_find[ATME_IDX_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      make_r    <= 1'b0;
      pending_r <= 1'b0;
      fail_r    <= 1'b0;
    end else begin
      if (wr_cmd) begin
        make_r <= pwdata[ATME_CMD_MAKE_BIT];
      end
      pending_r <= make_start;
      if (commit_go) begin
        // full table: entry not added, flagged instead
        fail_r <= stage_e.valid && !c_ok;
      end
    end
  end

  // aging: each period an untouched non-static entry loses its age flag, then its slot
  logic age_tick;
  assign age_tick = (age_cnt_r == AGE_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_cnt_r <= 33'h0_0000_0000;
    end else if (age_tick) begin
      age_cnt_r <= 33'h0_0000_0000;
    end else begin
      age_cnt_r <= age_cnt_r + 33'h0_0000_0001;
    end
  end

  // learning from source addresses; multicast sources never learned
  logic [ATME_IDX_W:0] s_find;
  logic [ATME_IDX_W:0] d_find;
  logic learn;
  logic learn_new;
  atme_entry_t d_e;
  always_comb s_find = find_mac(frame.sa);
  always_comb d_find = find_mac(frame.da);
  assign d_e       = tbl_r[d_find[ATME_IDX_W-1:0]];
  assign learn     = frame.valid && !frame.sa[0] && frame.ingress != 2'h3 && !commit_go;
  assign learn_new = learn && !s_find[ATME_IDX_W] && f_find[ATME_IDX_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ATME_ENTRIES; i++) begin
        tbl_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ATME_ENTRIES; i++) begin
        if (commit_go && c_ok && c_idx == ATME_IDX_W'(i)) begin
          tbl_r[i] <= stage_e;
        end else if (learn && s_find[ATME_IDX_W] && s_find[ATME_IDX_W-1:0] == ATME_IDX_W'(i)) begin
          if (!tbl_r[i].static_f) begin
            tbl_r[i].age_ovr <= 1'b1;
            tbl_r[i].ports   <= {1'b0, frame.ingress};
          end
        end else if (learn_new && f_find[ATME_IDX_W-1:0] == ATME_IDX_W'(i)) begin
          tbl_r[i] <= '{valid: 1'b1, age_ovr: 1'b1, static_f: 1'b0, filter: 1'b0,
                        pri_en: 1'b0, pri: 3'h0, ports: {1'b0, frame.ingress},
                        mac: frame.sa};
        end else if (age_tick && tbl_r[i].valid && !tbl_r[i].static_f) begin
          if (tbl_r[i].age_ovr) begin
            tbl_r[i].age_ovr <= 1'b0;
          end else begin
            tbl_r[i].valid <= 1'b0;
          end
        end
      end
    end
  end

  // forwarding decision, registered one cycle after the frame
  logic [2:0] dis_vec;
  logic [2:0] fw_vec;
  logic       ovr;
  logic       in_ok;
  logic [2:0] in_bit;
  logic [2:0] dest;
  logic [2:0] eg_ok;
  for (genvar p = 0; p < 3; p++) begin : g_pst
    assign dis_vec[p] = port_state[2*p +: 2] == ATME_PST_DISABLED;
    assign fw_vec[p]  = port_state[2*p +: 2] == ATME_PST_FORWARD;
    assign eg_ok[p]   = ovr ? !dis_vec[p] : fw_vec[p];
  end
  assign ovr    = d_find[ATME_IDX_W] && d_e.static_f && d_e.age_ovr;
  assign in_bit = 3'h1 << frame.ingress;
  assign in_ok  = frame.ingress != 2'h3 && (ovr ? !dis_vec[frame.ingress]
                                                : fw_vec[frame.ingress]);
  assign dest   = d_find[ATME_IDX_W] ? port_mask(d_e.ports) : 3'h7;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_r <= '0;
    end else begin
      fwd_r.valid <= frame.valid;
      fwd_r.drop  <= frame.valid && (!in_ok || (d_find[ATME_IDX_W] && d_e.filter));
      fwd_r.mask  <= (in_ok && !(d_find[ATME_IDX_W] && d_e.filter))
                   ? (dest & eg_ok & ~in_bit) : 3'h0;
      fwd_r.pri_valid <= frame.valid && d_find[ATME_IDX_W] && d_e.pri_en && dapri_r;
      fwd_r.pri   <= d_e.pri_en ? d_e.pri : 3'h0;
    end
  end
  assign fwd = fwd_r;

  // checks
  logic key_hit;
  assign key_hit = c_find[ATME_IDX_W];

  property p_low_store;
    @(posedge pclk) disable iff (!presetn)
      wr_low |=> stage_low_r == $past(pwdata);
  endproperty
  a_low_store: assert property (p_low_store) else $error("low stage not stored");

  property p_high_rsvd;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && reg_hit(paddr, ATME_IDX_STAGE_HIGH) |=> prdata[31:27] == 5'h00;
  endproperty
  a_high_rsvd: assert property (p_high_rsvd) else $error("reserved bits nonzero");

  property p_make_pend;
    @(posedge pclk) disable iff (!presetn)
      make_start |=> pending_r ##1 !pending_r;
  endproperty
  a_make_pend: assert property (p_make_pend) else $error("pending pulse wrong");

  property p_commit_add;
    @(posedge pclk) disable iff (!presetn)
      commit_go && stage_e.valid && c_ok |=> key_hit;
  endproperty
  a_commit_add: assert property (p_commit_add) else $error("entry not added");

  property p_commit_del;
    @(posedge pclk) disable iff (!presetn)
      commit_go && !stage_e.valid && key_hit |=> !key_hit;
  endproperty
  a_commit_del: assert property (p_commit_del) else $error("entry not removed");

  property p_filter;
    @(posedge pclk) disable iff (!presetn)
      frame.valid && d_find[ATME_IDX_W] && d_e.filter |=> fwd.drop && fwd.mask == 3'h0;
  endproperty
  a_filter: assert property (p_filter) else $error("filtered frame passed");

  property p_no_disabled;
    @(posedge pclk) disable iff (!presetn)
      frame.valid |=> (fwd.mask & $past(dis_vec)) == 3'h0;
  endproperty
  a_no_disabled: assert property (p_no_disabled) else $error("disabled port used");

  property p_pri_gate;
    @(posedge pclk) disable iff (!presetn)
      frame.valid && !(d_e.pri_en && dapri_r) |=> !fwd.pri_valid;
  endproperty
  a_pri_gate: assert property (p_pri_gate) else $error("priority used");

  for (genvar i = 0; i < ATME_ENTRIES; i++) begin : g_chk
    property p_static_keep;
      @(posedge pclk) disable iff (!presetn)
        tbl_r[i].valid && tbl_r[i].static_f && !commit_go |=> $stable(tbl_r[i]);
    endproperty
    a_static_keep: assert property (p_static_keep) else $error("static entry changed");

    property p_age_out;
      @(posedge pclk) disable iff (!presetn)
        age_tick && tbl_r[i].valid && !tbl_r[i].static_f && !tbl_r[i].age_ovr
        && !commit_go && !learn |=> !tbl_r[i].valid;
    endproperty
    a_age_out: assert property (p_age_out) else $error("idle entry kept");
  end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb;
  import atme_pkg::*;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [17:0]         paddr = '0;
  logic [31:0]         pwdata = '0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  atme_frame_t         frame = '0;
  logic [5:0]          port_state = 6'h3f;
  atme_fwd_t           fwd;
  logic [32:0]         rq[$];
  atme_fwd_t           fq[$];
  int                  mismatches = 0;
  int                  checks_done = 0;
  logic [31:0]         lo;
  logic [47:0]         m;
  logic [47:0]         a;
  logic [47:0]         b;
  logic [47:0]         s;
  logic [2:0]          p;
  localparam logic [2:0]  PMAP [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
  // multicast source so lookups never learn
  localparam logic [47:0] SMC = 48'h0000_0000_0001;
  localparam logic [47:0] DMC = 48'h0000_0000_0003;

  always #20 pclk = ~pclk;

  atme_entry_stage #(.AGE_CYCLES(64)) atme_entry_stage_i (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .frame      (frame),
    .port_state (port_state),
    .fwd        (fwd)
  );

  task end_sim;
    // a result that never showed up leaves its note behind
    if (rq.size() != 0 || fq.size() != 0) begin
      mismatches++;
      $display("MISMATCH queue exp 0 got %0d", rq.size() + fq.size());
    end
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task cmp_rd;
    logic [32:0] e;
    checks_done++;
    e = rq.size() ? rq.pop_front() : ~{pslverr, prdata};
    if ({pslverr, prdata} !== e) begin
      mismatches++;
      $display("MISMATCH apb_read exp %h got %h", e, {pslverr, prdata});
    end
  endtask

  task cmp_fwd;
    atme_fwd_t e;
    atme_fwd_t g;
    checks_done++;
    e = fq.size() ? fq.pop_front() : ~fwd;
    g = fwd;
    // priority value is only meaningful when flagged
    if (e.pri_valid === 1'b0) g.pri = e.pri;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH fwd exp %h got %h", e, fwd);
    end
  endtask

  // read data is taken at the edge where the access completes
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) cmp_rd();
  end

  always @(negedge pclk) begin
    if (fwd.valid === 1'b1) cmp_fwd();
  end

  task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rd(input logic [15:0] idx, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, idx, 32'h0);
  endtask

  function automatic logic [31:0] hw(input logic [4:0] fl, input logic [2:0] pr,
                                     input logic [2:0] pt, input logic [15:0] mh);
    return {5'h0, fl, pr, pt, mh};
  endfunction

  function automatic atme_fwd_t ef(input logic d, input logic [2:0] mk, input logic pv,
                                   input logic [2:0] pr);
    return {1'b1, d, mk, pv, pr};
  endfunction

  task commit(input logic [31:0] h, input logic [31:0] l);
    apb(1'b1, ATME_IDX_STAGE_LOW, l);
    apb(1'b1, ATME_IDX_STAGE_HIGH, h);
    apb(1'b1, ATME_IDX_CMD, 32'h1 << ATME_CMD_MAKE_BIT);
    rd(ATME_IDX_CMD_STS, 33'h0);
    rd(ATME_IDX_CMD, {1'b0, 32'h1 << ATME_CMD_MAKE_BIT});
    apb(1'b1, ATME_IDX_CMD, 32'h0);
  endtask

  task send(input logic [1:0] ing, input logic [47:0] sa, input logic [47:0] da,
            input atme_fwd_t e);
    fq.push_back(e);
    frame <= {1'b1, ing, sa, da};
    @(posedge pclk);
    frame.valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim();
  end

  initial begin
    void'($urandom(32'hd04b9298));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ATME_IDX_STAGE_LOW, 33'h0);
    rd(ATME_IDX_STAGE_HIGH, 33'h0);
    rd(16'h1803, 33'h1_0000_0000);
    lo = $urandom();
    apb(1'b1, ATME_IDX_STAGE_LOW, lo);
    rd(ATME_IDX_STAGE_LOW, {1'b0, lo});
    apb(1'b1, ATME_IDX_STAGE_HIGH, 32'hffff_ffff);
    rd(ATME_IDX_STAGE_HIGH, 33'h0_07ff_ffff);
    m[31:0] = $urandom();
    m[47:32] = 16'($urandom());
    for (int c = 0; c < 8; c++) begin
      commit(hw(5'b10100, 3'h0, 3'(c), m[47:32]), m[31:0]);
      send(2'd0, SMC, m, ef(1'b0, PMAP[c] & 3'b110, 1'b0, 3'h0));
    end
    send(2'd0, SMC, m ^ 48'h8000_0000_0000, ef(1'b0, 3'b110, 1'b0, 3'h0));
    send(2'd0, SMC, m ^ 48'h1, ef(1'b0, 3'b110, 1'b0, 3'h0));
    commit(hw(5'b10110, 3'h0, 3'd7, m[47:32]), m[31:0]);
    send(2'd0, SMC, m, ef(1'b1, 3'b000, 1'b0, 3'h0));
    p = 3'($urandom());
    commit(hw(5'b10101, p, 3'd7, m[47:32]), m[31:0]);
    send(2'd0, SMC, m, ef(1'b0, 3'b110, 1'b0, p));
    apb(1'b1, ATME_IDX_INGRESS_CFG, 32'h1 << ATME_CFG_DAPRI_BIT);
    send(2'd0, SMC, m, ef(1'b0, 3'b110, 1'b1, p));
    commit(hw(5'b10100, p, 3'd1, m[47:32]), m[31:0]);
    send(2'd0, SMC, m, ef(1'b0, 3'b010, 1'b0, p));
    commit(hw(5'b00100, p, 3'd1, m[47:32]), m[31:0]);
    send(2'd0, SMC, m, ef(1'b0, 3'b110, 1'b0, 3'h0));
    commit(hw(5'b10100, 3'h0, 3'd7, m[47:32]), m[31:0]);
    // port 0 blocking, port 1 disabled, port 2 blocking
    port_state <= 6'b01_00_01;
    send(2'd0, SMC, m, ef(1'b1, 3'b000, 1'b0, 3'h0));
    commit(hw(5'b11100, 3'h0, 3'd7, m[47:32]), m[31:0]);
    send(2'd0, SMC, m, ef(1'b0, 3'b100, 1'b0, 3'h0));
    port_state <= 6'h3f;
    a = 48'h0a0a_0000_1000;
    b = 48'h0b0b_0000_2000;
    s = 48'h0c0c_0000_3000;
    commit(hw(5'b11000, 3'h0, 3'd1, a[47:32]), a[31:0]);
    // source hits keep the entry alive across several aging periods
    repeat (6) begin
      repeat (40) @(posedge pclk);
      send(2'd1, a, DMC, ef(1'b0, 3'b101, 1'b0, 3'h0));
    end
    send(2'd0, SMC, a, ef(1'b0, 3'b010, 1'b0, 3'h0));
    commit(hw(5'b11000, 3'h0, 3'd1, b[47:32]), b[31:0]);
    commit(hw(5'b10100, 3'h0, 3'd2, s[47:32]), s[31:0]);
    repeat (200) @(posedge pclk);
    send(2'd0, SMC, b, ef(1'b0, 3'b110, 1'b0, 3'h0));
    send(2'd0, SMC, s, ef(1'b0, 3'b100, 1'b0, 3'h0));
    end_sim();
  end
endmodule
